// File: include/low_irq_cfg.svh
// constants of the proximity recalibration and low-interrupt enable registers
// assumes inclusion by bare name from the package and the design file
`ifndef LOW_IRQ_CFG_SVH
`define LOW_IRQ_CFG_SVH

`define LIC_ADDR_W 10
`define LIC_DATA_W 16
`define LIC_STAGES 12

`define LIC_OFF_RECAL_TIME 10'h004
`define LIC_OFF_LOW_IRQ_EN 10'h005

`define LIC_FP_RECAL_LSB 0
`define LIC_FP_RECAL_MSB 9
`define LIC_LP_RECAL_LSB 10
`define LIC_LP_RECAL_MSB 15
`define LIC_FP_RECAL_RST 10'h3FF
`define LIC_LP_RECAL_RST 6'h3F

`define LIC_STAGE_EN_LSB 0
`define LIC_STAGE_EN_MSB 11
`define LIC_PIN_FUNC_LSB 12
`define LIC_PIN_FUNC_MSB 13
`define LIC_PIN_TRIG_LSB 14
`define LIC_PIN_TRIG_MSB 15
`define LIC_LOW_IRQ_EN_RST 16'h0000
`define LIC_SYNC_FILL 2'h3

`endif

// File: include/low_irq_pkg.sv
// types shared by the low-interrupt enable and pin configuration block
// assumes low_irq_cfg.svh is on the include path
`include "low_irq_cfg.svh"

package low_irq_pkg;

    // pin function field encodings
    typedef enum logic [1:0] {
        PIN_OFF = 2'h0,
        PIN_INPUT = 2'h1,
        PIN_OUT_LOW = 2'h2,
        PIN_OUT_HIGH = 2'h3
    } pin_func_t;

    // input trigger field encodings
    typedef enum logic [1:0] {
        TRIG_LEVEL_LOW = 2'h0,
        TRIG_RISE = 2'h1,
        TRIG_FALL = 2'h2,
        TRIG_LEVEL_HIGH = 2'h3
    } pin_trig_t;

    // one register access from the serial interface logic
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`LIC_ADDR_W-1:0] addr;
        logic [`LIC_DATA_W-1:0] wdata;
    } reg_req_t;

    // pin drive toward the pad
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

endpackage

// File: design/low_irq_enable_and_pin_config.sv
// recalibration time register, low-threshold interrupt enables and pin setup
// assumes register accesses come from serial logic on clk; pin is async
//
// Notes on behaviour
// - stage enable bit passes its low event
// - pin field 00 disables, 01 input
// - pin field 10 drives pin_assert active low, 11 active high
// - trigger 00 low level, 11 high
// - trigger 01 rising edge, 10 falling
// - full power recal bits 9:0, reset ones
// - low power recal bits 15:10, reset ones
// - enables, pin function, trigger reset zero
`timescale 1ns/1ps
`include "low_irq_cfg.svh"

module low_irq_enable_and_pin_config (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access from serial interface logic
    input low_irq_pkg::reg_req_t req,
    output logic [`LIC_DATA_W-1:0] rdata,
    output logic rvalid,
    // conversion engine
    input wire logic [`LIC_STAGES-1:0] stage_low_exceeded,
    input wire logic other_irq,
    input wire logic pin_assert,
    output logic [`LIC_DATA_W-1:0] recal_time,
    // pins
    output logic int_n,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_trigger
);

    logic [`LIC_DATA_W-1:0] recal_reg;
    logic [`LIC_DATA_W-1:0] low_en_reg;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [1:0] sync_fill;

    // trigger decode of the synchronised pin for one trigger setting
    function automatic logic trig_hit(
        input logic [1:0] trig,
        input logic level,
        input logic up,
        input logic down
    );
        trig_hit = 1'b0;
        case (trig)
            low_irq_pkg::TRIG_LEVEL_LOW: trig_hit = ~level;
            low_irq_pkg::TRIG_LEVEL_HIGH: trig_hit = level;
            low_irq_pkg::TRIG_RISE: trig_hit = up;
            low_irq_pkg::TRIG_FALL: trig_hit = down;
        endcase
    endfunction

    wire hit_recal = req.addr == `LIC_OFF_RECAL_TIME;
    wire hit_low_en = req.addr == `LIC_OFF_LOW_IRQ_EN;
    wire [`LIC_STAGES-1:0] stage_en =
        low_en_reg[`LIC_STAGE_EN_MSB:`LIC_STAGE_EN_LSB];
    wire [`LIC_STAGES-1:0] stage_hit;
    wire [1:0] pin_func = low_en_reg[`LIC_PIN_FUNC_MSB:`LIC_PIN_FUNC_LSB];
    wire [1:0] pin_trig = low_en_reg[`LIC_PIN_TRIG_MSB:`LIC_PIN_TRIG_LSB];
    wire pin_is_input = pin_func == low_irq_pkg::PIN_INPUT;
    wire pin_is_out = pin_func[1];
    // edges held off until the chain holds real pin history after reset
    wire sync_ready = sync_fill == `LIC_SYNC_FILL;
    wire rise = sync_ready & pin_s2 & ~pin_prev;
    wire fall = sync_ready & ~pin_s2 & pin_prev;
    wire next_trigger = pin_is_input &
        trig_hit(pin_trig, pin_s2, rise, fall);
    wire low_any = |stage_hit;

    // each stage event passes only with its own enable bit
    for (genvar i = 0; i < `LIC_STAGES; i++) begin : g_stage
        assign stage_hit[i] = stage_low_exceeded[i] & stage_en[i];
    end
    wire next_int_n = ~(low_any | other_irq | next_trigger);
    wire next_pin_out = (pin_func == low_irq_pkg::PIN_OUT_HIGH) ?
        pin_assert : ~pin_assert;
    wire [`LIC_DATA_W-1:0] next_rdata =
        hit_recal ? recal_reg : (hit_low_en ? low_en_reg : 16'h0000);

    assign recal_time = recal_reg;

    // register bank
    always_ff @(posedge clk) begin
        if (rst) begin
            recal_reg <= {`LIC_LP_RECAL_RST, `LIC_FP_RECAL_RST};
            low_en_reg <= `LIC_LOW_IRQ_EN_RST;
        end else if (req.wr) begin
            if (hit_recal) begin
                recal_reg <= req.wdata;
            end
            if (hit_low_en) begin
                low_en_reg <= req.wdata;
            end
        end
    end

    // read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= next_rdata;
            end
        end
    end

    // pin synchroniser and edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_prev <= 1'b0;
            sync_fill <= 2'h0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
            if (sync_fill != `LIC_SYNC_FILL) begin
                sync_fill <= sync_fill + 2'h1;
            end
        end
    end

    // registered pin and interrupt outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            int_n <= 1'b1;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            pin_trigger <= 1'b0;
        end else begin
            int_n <= next_int_n;
            pin_out <= pin_is_out & next_pin_out;
            pin_oe <= pin_is_out;
            pin_trigger <= next_trigger;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_stage_low_irq: assert property (
        (|(stage_low_exceeded & stage_en)) |=> !int_n)
        else $error("enabled low event did not assert int_n");
    a_idle_int_high: assert property (
        (!(|(stage_low_exceeded & stage_en)) && !other_irq
            && !next_trigger) |=> int_n)
        else $error("int_n asserted with no source");
    a_pin_off_quiet: assert property (
        (pin_func == 2'h0) |=> (!pin_oe && !pin_trigger))
        else $error("disabled pin is active");
    a_pin_out_polarity: assert property (
        (pin_func[1]) |=> (pin_oe && pin_out ==
            ($past(pin_func) == 2'h3 ? $past(pin_assert)
                                     : !$past(pin_assert))))
        else $error("pin output polarity wrong");
    a_level_low_trig: assert property (
        (pin_func == 2'h1 && pin_trig == 2'h0 && !pin_s2) |=> pin_trigger)
        else $error("low level trigger missed");
    a_level_high_trig: assert property (
        (pin_func == 2'h1 && pin_trig == 2'h3 && pin_s2) |=> pin_trigger)
        else $error("high level trigger missed");
    a_rise_trig: assert property (
        (pin_func == 2'h1 && pin_trig == 2'h1 && pin_s2
            && !$past(pin_s2)) |=> pin_trigger)
        else $error("rising edge trigger missed");
    a_fall_trig: assert property (
        (pin_func == 2'h1 && pin_trig == 2'h2 && pin_s2 ##1 !pin_s2
            && pin_func == 2'h1 && pin_trig == 2'h2) |=> pin_trigger)
        else $error("falling edge trigger missed");
    a_reset_values: assert property (
        $past(rst) |-> (recal_reg == 16'hFFFF && low_en_reg == 16'h0000))
        else $error("reset value wrong");
    a_read_back: assert property (
        (req.wr && hit_low_en && !req.rd) ##1 (req.rd && hit_low_en
            && !req.wr) |=> (rvalid && rdata == $past(req.wdata, 2)))
        else $error("read did not return written value");

    // register bus answers and writes
    a_read_answer: assert property (
        req.rd |=> rvalid)
        else $error("read got no rvalid pulse");
    a_rvalid_single: assert property (
        !req.rd |=> !rvalid)
        else $error("rvalid without a read");
    a_rdata_hold: assert property (
        !req.rd |=> $stable(rdata))
        else $error("rdata changed without a read");
    a_unmapped_zero: assert property (
        (req.rd && !hit_recal && !hit_low_en) |=> (rdata == 16'h0000))
        else $error("unmapped read not zero");
    a_recal_write: assert property (
        (req.wr && hit_recal) |=> (recal_time == $past(req.wdata)))
        else $error("recal time write lost");
    a_low_en_write: assert property (
        (req.wr && hit_low_en) |=> (low_en_reg == $past(req.wdata)))
        else $error("low enable write lost");

    // pin outputs and triggers
    a_pin_idle_out: assert property (
        (!pin_func[1]) |=> (!pin_oe && !pin_out))
        else $error("pin driven while not an output");
    a_trig_input_only: assert property (
        (pin_func != 2'h1) |=> !pin_trigger)
        else $error("trigger while pin not an input");
    a_rise_single: assert property (
        (pin_func == 2'h1 && pin_trig == 2'h1 && !(pin_s2 && !pin_prev))
            |=> !pin_trigger)
        else $error("rising edge trigger too long");

    c_low_irq: cover property (!int_n && (|stage_en));
    c_rise_trig: cover property (pin_trig == 2'h1 && pin_trigger);
    c_pin_out: cover property (pin_oe && pin_out);
    c_read: cover property (rvalid && rdata != 16'h0000);
    c_fall_trig: cover property (pin_trig == 2'h2 && pin_trigger);

endmodule

// File: bench/host_model.sv
// host model: issues register writes and reads on the request port
// assumes callers enter its tasks just after a rising edge of clk
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // register port
    output low_irq_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    initial req = '0;
    task automatic put(input logic [9:0] a, input logic [15:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge clk);
    endtask
    task automatic put_get(input logic [9:0] a, input logic [15:0] w,
                           output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = '0;
        req <= '{1'b1, 1'b0, a, w};
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, w};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, ~w};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                d = rdata;
            end
        end
    endtask
    task automatic get(input logic [9:0] a, output logic [15:0] d,
                       output logic ok);
        ok = 1'b0;
        d = '0;
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                d = rdata;
            end
        end
    endtask
endmodule

// File: bench/low_irq_enable_and_pin_config_bench.sv
// self-checking bench of the recal time and low-enable/pin registers
// assumes host_model drives the register port
`timescale 1ns/1ps
module low_irq_enable_and_pin_config_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    low_irq_pkg::reg_req_t req;
    logic [15:0] rdata, recal_time;
    logic [11:0] stage_low_exceeded = '0;
    logic rvalid, int_n, pin_out, pin_oe, pin_trigger;
    logic other_irq = 1'b0, pin_assert = 1'b0, pin_in = 1'b0;
    int failures = 0;
    int n_compared = 0;
    always #20 clk = ~clk;
    host_model i_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    low_irq_enable_and_pin_config i_dut (.clk(clk), .rst(rst), .req(req),
        .rdata(rdata), .rvalid(rvalid), .recal_time(recal_time),
        .stage_low_exceeded(stage_low_exceeded), .other_irq(other_irq),
        .pin_assert(pin_assert), .int_n(int_n), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_trigger(pin_trigger));
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        i_host.get(a, d, ok);
        if (!ok) begin
            failures++;
            results();
        end else begin
            chk(d, exp);
        end
    endtask
    task automatic wr_rd(input logic [9:0] a, input logic [15:0] w);
        logic [15:0] d;
        logic ok;
        i_host.put_get(a, w, d, ok);
        if (!ok) begin
            failures++;
            results();
        end else begin
            chk(d, w);
        end
    endtask
    task automatic t_reset();
        rd(10'h004, 16'hFFFF);
        chk(recal_time, 16'hFFFF);
        rd(10'h005, 16'h0000);
        chk({int_n, pin_oe, pin_trigger}, 16'h0004);
        i_host.put(10'h004, 16'hA955);
        rd(10'h004, 16'hA955);
        chk(recal_time, 16'hA955);
        $display("done reset");
    endtask
    task automatic t_stage();
        wr_rd(10'h005, 16'h0801);
        i_host.put(10'h006, 16'h0FFF);
        rd(10'h006, 16'h0000);
        stage_low_exceeded <= 12'h7FE;
        cyc(2);
        chk(int_n, 1'b1);
        stage_low_exceeded <= 12'h800;
        cyc(2);
        chk(int_n, 1'b0);
        stage_low_exceeded <= 12'h000;
        other_irq <= 1'b1;
        cyc(2);
        chk(int_n, 1'b0);
        other_irq <= 1'b0;
        cyc(2);
        chk(int_n, 1'b1);
        $display("done stage");
    endtask
    task automatic t_out();
        wr_rd(10'h005, 16'h2000);
        pin_assert <= 1'b1;
        cyc(2);
        chk({pin_oe, pin_out}, 16'h0002);
        pin_assert <= 1'b0;
        cyc(2);
        chk({pin_oe, pin_out}, 16'h0003);
        i_host.put(10'h005, 16'h3000);
        pin_assert <= 1'b1;
        cyc(2);
        chk({pin_oe, pin_out}, 16'h0003);
        i_host.put(10'h005, 16'h0000);
        cyc(4);
        chk({pin_oe, pin_trigger, int_n}, 16'h0001);
        $display("done output");
    endtask
    task automatic t_trig();
        i_host.put(10'h005, 16'h1000);
        cyc(1);
        chk({pin_oe, pin_trigger, int_n}, 16'h0002);
        pin_in <= 1'b1;
        cyc(4);
        chk(pin_trigger, 1'b0);
        i_host.put(10'h005, 16'hD000);
        cyc(1);
        chk(pin_trigger, 1'b1);
        pin_in <= 1'b0;
        cyc(4);
        chk(pin_trigger, 1'b0);
        i_host.put(10'h005, 16'h5000);
        pin_in <= 1'b1;
        cyc(4);
        chk(pin_trigger, 1'b1);
        cyc(1);
        chk(pin_trigger, 1'b0);
        i_host.put(10'h005, 16'h9000);
        pin_in <= 1'b0;
        cyc(4);
        chk(pin_trigger, 1'b1);
        cyc(1);
        chk(pin_trigger, 1'b0);
        $display("done trigger");
    endtask
    initial begin
        cyc(3);
        rst <= 1'b0;
        t_reset();
        t_stage();
        t_out();
        t_trig();
        results();
    end
endmodule
